// ==== pkg/fsp_pkg.sv ====
/*
 * Shared constants for the flash security and protection block:
 * register addresses, field positions, reset values and reserved windows.
 * Assumes a 16-bit CPU address space and an 8-bit data path.
 */
package fsp_pkg;
   // Register addresses on the CPU bus
   localparam logic [15:0] FSP_ADR_OPTION   = 16'h1821;
   localparam logic [15:0] FSP_ADR_CONFIG   = 16'h1823;
   localparam logic [15:0] FSP_ADR_PROT     = 16'h1824;
   localparam logic [15:0] FSP_ADR_STATUS   = 16'h1825;
   localparam logic [15:0] FSP_ADR_COMMAND  = 16'h1826;
   // Nonvolatile bytes copied at reset
   localparam logic [15:0] FSP_ADR_NV_PROT  = 16'hFFBD;
   localparam logic [15:0] FSP_ADR_NV_OPT   = 16'hFFBF;
   // Backdoor key window
   localparam logic [15:0] FSP_ADR_KEY_LO   = 16'hFFB0;
   localparam logic [15:0] FSP_ADR_KEY_HI   = 16'hFFB7;
   // Ranges open to the SPI access port while secured
   localparam logic [15:0] FSP_SPI_A_LO     = 16'h0000;
   localparam logic [15:0] FSP_SPI_A_HI     = 16'h008F;
   localparam logic [15:0] FSP_SPI_B_LO     = 16'h1800;
   localparam logic [15:0] FSP_SPI_B_HI     = 16'h188F;
   // Security code values
   localparam logic [1:0]  FSP_SEC_OPEN     = 2'h2;
   localparam logic [1:0]  FSP_SEC_ERASED   = 2'h3;
   // Field positions
   localparam int FSP_CFG_STEER  = 5;
   localparam int FSP_OPT_ALLOW  = 7;
   localparam int FSP_OPT_NORED  = 6;
   localparam int FSP_PROT_OFF   = 0;
   localparam int FSP_ST_CBEF    = 7;
   localparam int FSP_ST_CCF     = 6;
   localparam int FSP_ST_PVIOL   = 5;
   localparam int FSP_ST_ACCERR  = 4;
   localparam int FSP_ST_BLANK   = 2;
   localparam int FSP_ST_FAIL    = 1;
   localparam int FSP_ST_DONE    = 0;
   // Low address bits below the protect-select field
   localparam int FSP_PAGE_BITS  = 9;
   localparam logic [8:0]  FSP_PAGE_ONES    = 9'h1FF;
   // Reset values; the extended status layout adds fail and done bits
   localparam logic [7:0]  FSP_CFG_RESET    = 8'h00;
   localparam logic [7:0]  FSP_ST_RESET     = 8'hC0;
   localparam logic [7:0]  FSP_ST_RESET_EXT = 8'hC1;
   localparam logic        FSP_ST_EXT       = 1'b0;
   localparam logic [7:0]  FSP_ZERO8        = 8'h00;
   localparam logic [2:0]  FSP_KEY_LAST     = 3'h7;
endpackage : fsp_pkg

// ==== pkg/fsp_key_if.sv ====
/*
 * Carrier between the register front end and the backdoor key comparator.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/100ps
interface fsp_key_if;
   logic       wr;     // User write into the key window
   logic [2:0] idx;    // Byte index within the window
   logic [7:0] data;   // Written byte
   logic       allow;  // Backdoor mechanism enabled
   logic       match;  // Eight bytes matched, one-cycle pulse
   modport front (output wr, idx, data, allow, input match);
   modport cmp   (input wr, idx, data, allow, output match);
endinterface : fsp_key_if

// ==== rtl/fsp_keycmp.sv ====
/*
 * Backdoor key comparator: counts in-order matching key bytes.
 * Assumes only user firmware writes reach it; debug writes are filtered upstream.
 */
`timescale 1ns/100ps
module fsp_keycmp
   import fsp_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [63:0] i_key,
   fsp_key_if.cmp           kif
);
   logic [2:0] next_byte;
   logic       hit;

   // Byte zero of the stored key sits in the low byte
   assign hit = kif.allow && (kif.data == i_key[kif.idx*8 +: 8]) && (kif.idx == next_byte);

   // Any out-of-order or wrong byte restarts the sequence
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         next_byte <= 3'h0;
         kif.match <= 1'b0;
      end else begin
         kif.match <= 1'b0;
         if (kif.wr) begin
            if (hit && next_byte == FSP_KEY_LAST) begin
               kif.match <= 1'b1;
               next_byte <= 3'h0;
            end else if (hit) begin
               next_byte <= next_byte + 3'h1;
            end else begin
               next_byte <= 3'h0;
            end
         end
      end
   end
endmodule : fsp_keycmp

// ==== rtl/fsp_spigate.sv ====
/*
 * SPI access window check: flags addresses outside the secured-mode ranges.
 * Purely combinational; the caller registers the outcome.
 */
`timescale 1ns/100ps
module fsp_spigate
   import fsp_pkg::*;
(
   input  wire logic [15:0] i_addr,
   input  wire logic        i_secured,
   output logic             o_refuse
);
   logic in_a;
   logic in_b;

   // Low range starts at zero, so only the top bound needs checking
   assign in_a     = i_addr <= FSP_SPI_A_HI;
   assign in_b     = (i_addr >= FSP_SPI_B_LO) && (i_addr <= FSP_SPI_B_HI);
   assign o_refuse = i_secured && !(in_a || in_b);
endmodule : fsp_spigate

// ==== rtl/fsp_top.sv ====
/*
 * Flash security and protection front end: security code, key steering,
 * protection boundary, command status flags, debug and SPI gating.
 * Assumes the CPU bus, debug front end, SPI front end and flash engine all
 * run on I_MCLK; nonvolatile bytes are stable on their inputs at reset release.
 */
`timescale 1ns/100ps
module fsp_top
   import fsp_pkg::*;
(
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_N,
   input  wire logic [15:0] I_ADDR,
   input  wire logic [7:0]  I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [7:0]  O_RDATA,
   input  wire logic [7:0]  I_NV_PROT,
   input  wire logic [7:0]  I_NV_OPT,
   input  wire logic [63:0] I_NV_KEY,
   input  wire logic        I_DBG_WR,
   input  wire logic [15:0] I_DBG_ADDR,
   input  wire logic [7:0]  I_DBG_WDATA,
   input  wire logic        I_DBG_MEM,
   output logic             O_DBG_DENY,
   input  wire logic        I_SPI_REQ,
   input  wire logic [15:0] I_SPI_ADDR,
   output logic             O_SPI_GO,
   output logic             O_SPI_ERR,
   output logic             O_CMD_WR,
   output logic      [15:0] O_CMD_ADDR,
   output logic      [7:0]  O_CMD_DATA,
   output logic             O_LAUNCH,
   output logic      [6:0]  O_CMD,
   input  wire logic        I_OP_DONE,
   input  wire logic        I_BLANK_OK,
   input  wire logic        I_OP_FAIL,
   input  wire logic        I_SEQ_ERR,
   output logic             O_SECURED
);
   fsp_key_if kif ();

   logic       loaded;
   logic [7:0] flash_config;
   logic [7:0] protection_boundary;
   logic [7:0] option_copy;
   logic [1:0] security_code;
   logic       cmd_buffer_empty, cmd_complete, protect_violation, access_error;
   logic       blank_verified, op_fail, pending;
   logic [6:0] cmd_code;
   logic       secured, in_key, key_steer, cpu_wr_status, launch_req;
   logic       tgt_protected, spi_refuse;
   logic [15:0] boundary;

   // Only the open pattern releases security
   assign secured   = security_code != FSP_SEC_OPEN;
   assign in_key    = (I_ADDR >= FSP_ADR_KEY_LO) && (I_ADDR <= FSP_ADR_KEY_HI);
   assign key_steer = flash_config[FSP_CFG_STEER];
   assign cpu_wr_status = I_WR && (I_ADDR == FSP_ADR_STATUS);
   assign launch_req    = cpu_wr_status && I_WDATA[FSP_ST_CBEF] && cmd_buffer_empty;

   // Boundary is the select field over all-ones page bits
   assign boundary = {protection_boundary[7:1], FSP_PAGE_ONES};
   assign tgt_protected = !protection_boundary[FSP_PROT_OFF]
                          && (O_CMD_ADDR > boundary);

   // Nonvolatile copies taken at the first edge after reset release
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         loaded              <= 1'b0;
         protection_boundary <= FSP_ZERO8;
         option_copy         <= FSP_ZERO8;
      end else if (!loaded) begin
         loaded              <= 1'b1;
         protection_boundary <= I_NV_PROT;
         option_copy         <= I_NV_OPT;
      end else if (I_DBG_WR && I_DBG_ADDR == FSP_ADR_PROT) begin
         protection_boundary <= I_DBG_WDATA;
      end
   end

   // Security code: reset value secured until the copy lands; unlock is sticky
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         security_code <= FSP_SEC_ERASED;
      end else if (!loaded) begin
         security_code <= I_NV_OPT[1:0];
      end else if (kif.match || (I_OP_DONE && I_BLANK_OK)) begin
         security_code <= FSP_SEC_OPEN;
      end
   end

   // Only the key-steering bit is writable in the config register
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flash_config <= FSP_CFG_RESET;
      end else if (I_WR && I_ADDR == FSP_ADR_CONFIG) begin
         flash_config[FSP_CFG_STEER] <= I_WDATA[FSP_CFG_STEER];
      end
   end

   // Key window writes go to the comparator only from user firmware
   assign kif.wr    = I_WR && in_key && key_steer;
   assign kif.idx   = I_ADDR[2:0];
   assign kif.data  = I_WDATA;
   assign kif.allow = option_copy[FSP_OPT_ALLOW];

   fsp_keycmp u_keycmp (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RST_N),
      .i_key   (I_NV_KEY),
      .kif     (kif.cmp)
   );

   // Array write latches the target; key window included when steered low
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_CMD_WR   <= 1'b0;
         O_CMD_ADDR <= 16'h0000;
         O_CMD_DATA <= FSP_ZERO8;
         pending    <= 1'b0;
      end else begin
         O_CMD_WR <= 1'b0;
         if (I_WR && I_ADDR >= FSP_ADR_KEY_LO && !(in_key && key_steer)
             && I_ADDR != FSP_ADR_NV_PROT && cmd_buffer_empty) begin
            O_CMD_WR   <= 1'b1;
            O_CMD_ADDR <= I_ADDR;
            O_CMD_DATA <= I_WDATA;
            pending    <= 1'b1;
         end else if (launch_req) begin
            pending    <= 1'b0;
         end
      end
   end

   // Command code register
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cmd_code <= 7'h00;
      end else if (I_WR && I_ADDR == FSP_ADR_COMMAND) begin
         cmd_code <= I_WDATA[6:0];
      end
   end

   // Launch: protected or incomplete commands are dropped here
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_LAUNCH <= 1'b0;
         O_CMD    <= 7'h00;
      end else begin
         O_LAUNCH <= launch_req && pending && !tgt_protected;
         O_CMD    <= cmd_code;
      end
   end

   // Buffer-empty and complete flags follow the engine
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cmd_buffer_empty <= FSP_ST_RESET[FSP_ST_CBEF];
         cmd_complete     <= FSP_ST_RESET[FSP_ST_CCF];
         blank_verified   <= 1'b0;
         op_fail          <= 1'b0;
      end else begin
         if (launch_req && pending && !tgt_protected) begin
            cmd_buffer_empty <= 1'b0;
            cmd_complete     <= 1'b0;
            blank_verified   <= 1'b0;
            op_fail          <= 1'b0;
         end else if (I_OP_DONE) begin
            cmd_buffer_empty <= 1'b1;
            cmd_complete     <= 1'b1;
            blank_verified   <= I_BLANK_OK;
            op_fail          <= I_OP_FAIL;
         end
      end
   end

   // Error flags are write-one-to-clear; a new event wins over the clear
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         protect_violation <= 1'b0;
         access_error      <= 1'b0;
      end else begin
         if (launch_req && pending && tgt_protected) begin
            protect_violation <= 1'b1;
         end else if (cpu_wr_status && I_WDATA[FSP_ST_PVIOL]) begin
            protect_violation <= 1'b0;
         end
         if (I_SEQ_ERR || (launch_req && !pending)) begin
            access_error <= 1'b1;
         end else if (cpu_wr_status && I_WDATA[FSP_ST_ACCERR]) begin
            access_error <= 1'b0;
         end
      end
   end

   // Read data; key window and unknown addresses read zero here
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_RDATA <= FSP_ZERO8;
      end else if (I_RD) begin
         if (I_ADDR == FSP_ADR_OPTION) begin
            O_RDATA <= {option_copy[FSP_OPT_ALLOW], option_copy[FSP_OPT_NORED],
                        4'h0, security_code};
         end else if (I_ADDR == FSP_ADR_CONFIG) begin
            O_RDATA <= flash_config;
         end else if (I_ADDR == FSP_ADR_PROT) begin
            O_RDATA <= {protection_boundary[7:1], protection_boundary[FSP_PROT_OFF]};
         end else if (I_ADDR == FSP_ADR_STATUS) begin
            O_RDATA <= {cmd_buffer_empty, cmd_complete, protect_violation,
                        access_error, 1'b0, blank_verified,
                        FSP_ST_EXT & op_fail, FSP_ST_EXT & cmd_complete};
         end else begin
            O_RDATA <= FSP_ZERO8;
         end
      end
   end

   // Debug memory accesses refused while secured
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DBG_DENY <= 1'b0;
         O_SECURED  <= 1'b1;
      end else begin
         O_DBG_DENY <= I_DBG_MEM && secured;
         O_SECURED  <= secured;
      end
   end

   fsp_spigate u_spigate (
      .i_addr    (I_SPI_ADDR),
      .i_secured (secured),
      .o_refuse  (spi_refuse)
   );

   // Refused SPI never reaches memory; error holds until the next request
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_SPI_GO  <= 1'b0;
         O_SPI_ERR <= 1'b0;
      end else begin
         O_SPI_GO <= I_SPI_REQ && !spi_refuse;
         if (I_SPI_REQ) begin
            O_SPI_ERR <= spi_refuse;
         end
      end
   end

   // Launch sequences, each used by one check
   sequence s_launch_bad;
      launch_req && pending && tgt_protected;
   endsequence
   sequence s_launch_ok;
      launch_req && pending && !tgt_protected;
   endsequence

   a_open_code: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      O_SECURED |-> $past(security_code) != FSP_SEC_OPEN)
      else $error("secured shown with open code");
   a_dbg_deny: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_DBG_MEM && secured |=> O_DBG_DENY)
      else $error("debug access not refused");
   a_unlock_key: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      kif.match && loaded |=> !secured)
      else $error("key match did not unsecure");
   a_spi_refuse: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_SPI_REQ && secured && I_SPI_ADDR > FSP_SPI_B_HI |=> O_SPI_ERR && !O_SPI_GO)
      else $error("spi outside window not refused");
   a_steer_cmd: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      kif.wr |=> !O_CMD_WR)
      else $error("key write started a command");
   a_prot_ro: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      loaded && !I_DBG_WR |=> $stable(protection_boundary))
      else $error("protection register changed without debug write");
   a_viol_drop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      s_launch_bad |=> protect_violation && !O_LAUNCH ##1 !O_LAUNCH)
      else $error("protected command not dropped");
   a_launch_go: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      s_launch_ok |=> O_LAUNCH && !cmd_buffer_empty && !cmd_complete)
      else $error("valid launch lost");
   a_nothing_prot: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      launch_req && pending && protection_boundary[FSP_PROT_OFF] |=> O_LAUNCH)
      else $error("launch refused while protection disabled");
   a_spi_hold: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !I_SPI_REQ |=> $stable(O_SPI_ERR))
      else $error("spi error did not hold");
endmodule : fsp_top

// ==== verification/fsp_engine_model.sv ====
/*
 * Flash engine stand-in: answers each launch with a done pulse after
 * a programmable delay, optionally qualified as a passed blank check.
 * Assumes one launch at a time on the shared bus clock.
 */
`timescale 1ns/100ps
module fsp_engine_model (
   input  wire logic       i_clk,
   input  wire logic       i_launch,
   input  wire logic       i_blank,
   input  wire logic [3:0] i_dly,
   output logic            o_done,
   output logic            o_blank_ok
);
   logic [3:0] cnt  = 4'h0;
   logic       busy = 1'b0;
   initial o_done = 1'b0;

   // Delay count; zero gives a prompt answer, larger values a slow one
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      if (i_launch) begin
         busy <= 1'b1;
         cnt  <= i_dly;
      end else if (busy && cnt == 4'h0) begin
         busy   <= 1'b0;
         o_done <= 1'b1;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end

   // Qualifier shown only beside done, low otherwise
   assign o_blank_ok = o_done & i_blank;
endmodule : fsp_engine_model

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the flash security and protection front end.
 * Assumes the engine model on the launch path; debug and SPI driven here.
 */
`timescale 1ns/100ps
module tb_top;
   import fsp_pkg::*;
   logic I_MCLK = 1'b0, I_RST_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
   logic [15:0] I_ADDR = 16'h0000, I_DBG_ADDR = 16'h0000, I_SPI_ADDR = 16'h0000;
   logic [7:0]  I_WDATA = 8'h00, I_DBG_WDATA = 8'h00, I_NV_PROT = 8'hFF;
   logic [7:0]  I_NV_OPT = 8'h83, O_RDATA, O_CMD_DATA;
   logic [63:0] I_NV_KEY = 64'h0123_4567_89AB_CDEF;
   logic I_DBG_WR = 1'b0, I_DBG_MEM = 1'b0, I_SPI_REQ = 1'b0, blank = 1'b0;
   logic O_DBG_DENY, O_SPI_GO, O_SPI_ERR, O_CMD_WR, O_LAUNCH, O_SECURED;
   logic I_OP_DONE, I_BLANK_OK;
   logic [15:0] O_CMD_ADDR;
   logic [6:0]  O_CMD;
   logic [3:0]  dly = 4'h0;
   int n_fail = 0, num_checks = 0, cycles = 0;
   logic [15:0] spi_a [7] = '{16'h0000, 16'h008F, 16'h0090, 16'h17FF,
                              16'h1800, 16'h188F, 16'h1890};
   logic spi_ok [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [7:0] prot_v [3] = '{8'hFC, 8'hFE, 8'hFD};
   logic [15:0] adr_v [3] = '{16'hFFB0, 16'hFFC0, 16'hFFC0};
   logic go_v [3] = '{1'b0, 1'b1, 1'b1};

   fsp_top u_dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
      .I_NV_PROT(I_NV_PROT), .I_NV_OPT(I_NV_OPT), .I_NV_KEY(I_NV_KEY),
      .I_DBG_WR(I_DBG_WR), .I_DBG_ADDR(I_DBG_ADDR), .I_DBG_WDATA(I_DBG_WDATA),
      .I_DBG_MEM(I_DBG_MEM), .O_DBG_DENY(O_DBG_DENY), .I_SPI_REQ(I_SPI_REQ),
      .I_SPI_ADDR(I_SPI_ADDR), .O_SPI_GO(O_SPI_GO), .O_SPI_ERR(O_SPI_ERR),
      .O_CMD_WR(O_CMD_WR), .O_CMD_ADDR(O_CMD_ADDR), .O_CMD_DATA(O_CMD_DATA),
      .O_LAUNCH(O_LAUNCH), .O_CMD(O_CMD), .I_OP_DONE(I_OP_DONE),
      .I_BLANK_OK(I_BLANK_OK), .I_OP_FAIL(1'b0), .I_SEQ_ERR(1'b0),
      .O_SECURED(O_SECURED));

   fsp_engine_model u_eng (.i_clk(I_MCLK), .i_launch(O_LAUNCH), .i_blank(blank),
      .i_dly(dly), .o_done(I_OP_DONE), .o_blank_ok(I_BLANK_OK));

   // Bus clock, 100 ns period
   always #50 I_MCLK = ~I_MCLK;

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge I_MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic do_reset();
      @(negedge I_MCLK) I_RST_N = 1'b0;
      repeat (10) @(negedge I_MCLK);
      I_RST_N = 1'b1;
      repeat (2) @(negedge I_MCLK);
   endtask : do_reset

   // One CPU write; pulses raised by it stand when this returns
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge I_MCLK);
      I_ADDR = a;
      I_WDATA = d;
      I_WR = 1'b1;
      @(negedge I_MCLK) I_WR = 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge I_MCLK);
      I_ADDR = a;
      I_RD = 1'b1;
      @(negedge I_MCLK) I_RD = 1'b0;
      chk(O_RDATA & m, e);
   endtask : rd

   task automatic dwr(input logic [15:0] a, input logic [7:0] d);
      @(negedge I_MCLK);
      I_DBG_ADDR = a;
      I_DBG_WDATA = d;
      I_DBG_WR = 1'b1;
      @(negedge I_MCLK) I_DBG_WR = 1'b0;
   endtask : dwr

   task automatic dmem(input logic deny);
      @(negedge I_MCLK) I_DBG_MEM = 1'b1;
      @(negedge I_MCLK) I_DBG_MEM = 1'b0;
      chk(O_DBG_DENY, deny);
   endtask : dmem

   task automatic spi(input logic [15:0] a, input logic ok);
      @(negedge I_MCLK);
      I_SPI_ADDR = a;
      I_SPI_REQ = 1'b1;
      @(negedge I_MCLK) I_SPI_REQ = 1'b0;
      chk(O_SPI_GO, ok);
      chk(O_SPI_ERR, !ok);
   endtask : spi

   // Array write, code, launch; busy flags checked before the engine answers
   task automatic cmd(input logic [15:0] a, input logic go);
      wr(a, 8'h5A);
      chk(O_CMD_ADDR, a);
      chk(O_CMD_DATA, 8'h5A);
      wr(FSP_ADR_COMMAND, 8'h20);
      wr(FSP_ADR_STATUS, 8'h80);
      chk(O_LAUNCH, go);
      if (go) begin
         chk(O_CMD, 7'h20);
         rd(FSP_ADR_STATUS, 8'h00, 8'hC0);
      end
      repeat (12) @(negedge I_MCLK);
   endtask : cmd

   initial begin
      // Every security code pattern, loaded at reset
      for (int c = 0; c < 4; c++) begin
         I_NV_OPT = {6'b10_0000, c[1:0]};
         do_reset();
         chk(O_SECURED, 16'(c != 2));
      end
      rd(FSP_ADR_OPTION, 8'h83, 8'hFF);
      rd(FSP_ADR_STATUS, FSP_ST_RESET, 8'hFF);
      rd(FSP_ADR_CONFIG, FSP_CFG_RESET, 8'hFF);
      rd(FSP_ADR_PROT, 8'hFF, 8'hFF);
      wr(FSP_ADR_PROT, 8'h00);
      rd(FSP_ADR_PROT, 8'hFF, 8'hFF);
      dmem(1'b1);
      foreach (spi_a[i]) spi(spi_a[i], spi_ok[i]);
      // Protection cases: above boundary, top select, disabled
      foreach (prot_v[i]) begin
         dly = i[0] ? 4'h0 : 4'h9;
         dwr(FSP_ADR_PROT, prot_v[i]);
         rd(FSP_ADR_PROT, prot_v[i], 8'hFF);
         wr(adr_v[i], 8'h11);
         chk(O_CMD_WR, 1'b1);
         cmd(adr_v[i], go_v[i]);
         rd(FSP_ADR_STATUS, go_v[i] ? 8'h00 : 8'h20, 8'h20);
         wr(FSP_ADR_STATUS, 8'h20);
         rd(FSP_ADR_STATUS, 8'h00, 8'h20);
      end
      rd(FSP_ADR_STATUS, FSP_ST_RESET, 8'hFF);
      // Launch with nothing registered sets the access error
      wr(FSP_ADR_STATUS, 8'h80);
      rd(FSP_ADR_STATUS, 8'h10, 8'h10);
      wr(FSP_ADR_STATUS, 8'h10);
      rd(FSP_ADR_STATUS, 8'h00, 8'h10);
      // Key entry: a pass with a wrong fourth byte first, then the right sequence
      wr(FSP_ADR_CONFIG, 8'h20);
      rd(FSP_ADR_CONFIG, 8'h20, 8'hFF);
      for (int k = 0; k < 16; k++) begin
         wr(FSP_ADR_KEY_LO + 16'(k % 8), I_NV_KEY[8*(k%8) +: 8] ^ 8'(k == 3));
         chk(O_CMD_WR, 1'b0);
         if (k % 8 == 7) begin
            repeat (3) @(negedge I_MCLK);
            chk(O_SECURED, 16'(k < 8));
         end
      end
      rd(FSP_ADR_OPTION, 8'h02, 8'h03);
      spi(16'h0090, 1'b1);
      dmem(1'b0);
      // Fresh reset secures again; a passed blank check opens it
      do_reset();
      chk(O_SECURED, 1'b1);
      blank = 1'b1;
      cmd(16'hFFC0, 1'b1);
      rd(FSP_ADR_STATUS, 8'h04, 8'h04);
      chk(O_SECURED, 1'b0);
      print_verdict();
   end
endmodule : tb_top
